// file: src/dfm_consts.svh
// constants for the digital I/O function mapper: register map, codes, sizes, reset threshold
`ifndef DFM_CONSTS_SVH
`define DFM_CONSTS_SVH
`define DFM_NUM_DI 5
`define DFM_NUM_DO 3
`define DFM_NUM_PIN 7
`define DFM_ADDR_W 8
`define DFM_OFS_DI_CFG0 8'h00
`define DFM_OFS_DO_CFG0 8'h14
`define DFM_OFS_FORCE_SEL 8'h20
`define DFM_OFS_FORCED_IN 8'h24
`define DFM_OFS_FORCED_OUT 8'h28
`define DFM_OFS_ROT_THRESH 8'h2C
`define DFM_OFS_STATUS 8'h30
// function codes hold the decimal code as a binary value
`define DFM_CODE_NONE 8'h00
`define DFM_FI_MOTOR_EN 8'h01
`define DFM_FI_FAULT_CLR 8'h02
`define DFM_FI_FWD_LIMIT 8'h0E
`define DFM_FI_REV_LIMIT 8'h0F
`define DFM_FI_ORIGIN 8'h1F
`define DFM_FI_HALT 8'h22
`define DFM_FI_LATCH_A 8'h26
`define DFM_FI_LATCH_B 8'h27
`define DFM_FO_READY 8'h01
`define DFM_FO_ROTATING 8'h02
`define DFM_FO_BRAKE 8'h09
`define DFM_FO_WARNING 8'h0A
`define DFM_FO_FAULT 8'h0B
`define DFM_FO_POS_CMP 8'h19
`define DFM_FO_SAFE_TORQUE 8'h20
`define DFM_FORCE_NONE 3'h0
`define DFM_FORCE_IN 3'h1
`define DFM_FORCE_OUT 3'h2
`define DFM_FORCE_BOTH 3'h3
`define DFM_FORCE_BUS_OUT 3'h4
`define DFM_RESP_OKAY 2'h0
`define DFM_RESP_SLVERR 2'h2
`define DFM_RST_THRESH 16'h00C8
`endif

// file: src/dfm_pkg.sv
// types shared by the digital I/O function mapper
package dfm_pkg;
  `include "dfm_consts.svh"

  typedef struct packed {
    logic sense;
    logic [7:0] code;
  } dfm_cfg_t;

  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } dfm_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dfm_axi_rsp_t;

  typedef struct packed {
    logic bus_control;
    logic drive_ready;
    logic signed [15:0] filt_speed;
    logic brake_active;
    logic warning;
    logic fault;
    logic pos_passed;
    logic [`DFM_NUM_DO-1:0] bus_do_enable;
    logic [`DFM_NUM_DO-1:0] bus_do_value;
  } dfm_drive_t;

  typedef struct packed {
    logic motor_enable;
    logic fault_clear_in;
    logic forward_limit_in;
    logic reverse_limit_in;
    logic origin_sensor_in;
    logic emergency_halt_in;
    logic latch_trigger_a;
    logic latch_trigger_b;
  } dfm_in_func_t;

  typedef struct packed {
    dfm_axi_rsp_t rsp;
    logic aw_held;
    logic w_held;
    logic [31:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    dfm_cfg_t [`DFM_NUM_DI-1:0] di_cfg;
    dfm_cfg_t [`DFM_NUM_DO-1:0] do_cfg;
    logic [2:0] force_sel;
    logic [`DFM_NUM_DI-1:0] forced_in;
    logic [`DFM_NUM_DO-1:0] forced_out;
    logic [15:0] thresh;
    logic [`DFM_NUM_PIN-1:0] sync1;
    logic [`DFM_NUM_PIN-1:0] sync2;
    logic [`DFM_NUM_PIN-1:0] sync3;
    logic [`DFM_NUM_PIN-1:0] pin_level;
    logic [`DFM_NUM_DI-1:0] din_level;
    logic [`DFM_NUM_DO-1:0] dout;
    dfm_in_func_t in_func;
  } dfm_state_t;
endpackage

// file: src/dfm_mapper.sv
// digital I/O function mapper with AXI4-Lite configuration slave
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`include "dfm_consts.svh"
module dfm_mapper (
  input wire logic I_CORE_CLK,
  input wire logic I_RESET,
  input wire dfm_pkg::dfm_axi_req_t I_AXI_REQ,
  output dfm_pkg::dfm_axi_rsp_t O_AXI_RSP,
  input wire logic [`DFM_NUM_DI-1:0] I_DIN,
  input wire logic I_SAFETY_INPUT_A,
  input wire logic I_SAFETY_INPUT_B,
  input wire dfm_pkg::dfm_drive_t I_DRIVE,
  output logic [`DFM_NUM_DO-1:0] O_DOUT,
  output dfm_pkg::dfm_in_func_t O_IN_FUNC
);
  import dfm_pkg::*;

  dfm_state_t q;
  dfm_state_t n;
  logic force_in_mode;
  logic force_out_mode;
  logic bus_out_mode;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = data[8*b +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [15:0] abs16(input logic signed [15:0] v);
    logic [15:0] r;
    r = v[15] ? 16'(-v) : 16'(v);
    return r;
  endfunction

  // bit 32 flags a mapped address, low word is the read value
  function automatic logic [32:0] reg_read(input dfm_state_t s, input logic [31:0] a);
    logic [32:0] r;
    r = {1'b0, 32'h0000_0000};
    if (a[31:`DFM_ADDR_W] == '0) begin
      for (int k = 0; k < `DFM_NUM_DI; k++) begin
        if (a[7:0] == 8'(`DFM_OFS_DI_CFG0 + 4 * k)) begin
          r = {1'b1, 23'h000000, s.di_cfg[k]};
        end
      end
      for (int k = 0; k < `DFM_NUM_DO; k++) begin
        if (a[7:0] == 8'(`DFM_OFS_DO_CFG0 + 4 * k)) begin
          r = {1'b1, 23'h000000, s.do_cfg[k]};
        end
      end
      case (a[7:0])
        `DFM_OFS_FORCE_SEL: r = {1'b1, 29'h00000000, s.force_sel};
        `DFM_OFS_FORCED_IN: r = {1'b1, 27'h0000000, s.forced_in};
        `DFM_OFS_FORCED_OUT: r = {1'b1, 29'h00000000, s.forced_out};
        `DFM_OFS_ROT_THRESH: r = {1'b1, 16'h0000, s.thresh};
        `DFM_OFS_STATUS: r = {1'b1, 8'h00, s.in_func, 2'h0, s.pin_level[6:5], 1'h0,
                              s.dout, 3'h0, s.din_level};
        default: r = r;
      endcase
    end
    return r;
  endfunction

  // output function activity by code; unknown or unassigned codes stay inactive
  function automatic logic fn_out(input logic [7:0] code, input dfm_drive_t d,
                                  input logic [15:0] thr, input logic [1:0] sto);
    logic act;
    act = 1'b0;
    case (code)
      `DFM_FO_READY: act = d.drive_ready;
      `DFM_FO_ROTATING: act = abs16(d.filt_speed) >= thr;
      `DFM_FO_BRAKE: act = d.brake_active;
      `DFM_FO_WARNING: act = d.warning;
      `DFM_FO_FAULT: act = d.fault;
      `DFM_FO_POS_CMP: act = d.pos_passed;
      `DFM_FO_SAFE_TORQUE: act = (sto == 2'h0);
      default: act = 1'b0;
    endcase
    return act;
  endfunction

  always_comb begin
    force_in_mode = (q.force_sel == `DFM_FORCE_IN) || (q.force_sel == `DFM_FORCE_BOTH);
    force_out_mode = (q.force_sel == `DFM_FORCE_OUT) || (q.force_sel == `DFM_FORCE_BOTH);
    bus_out_mode = (q.force_sel == `DFM_FORCE_BUS_OUT);
  end

  always_comb begin
    logic [32:0] rd;
    logic [31:0] wv;
    logic active;
    logic [7:0] code;
    dfm_in_func_t f;
    rd = {1'b0, 32'h0000_0000};
    wv = 32'h0000_0000;
    active = 1'b0;
    code = `DFM_CODE_NONE;
    f = '0;
    n = q;

    // write address and data are taken independently, response once both are held
    if (q.rsp.awready && I_AXI_REQ.awvalid) begin
      n.aw_held = 1'b1;
      n.awaddr = I_AXI_REQ.awaddr;
      n.rsp.awready = 1'b0;
    end
    if (q.rsp.wready && I_AXI_REQ.wvalid) begin
      n.w_held = 1'b1;
      n.wdata = I_AXI_REQ.wdata;
      n.wstrb = I_AXI_REQ.wstrb;
      n.rsp.wready = 1'b0;
    end
    if (q.aw_held && q.w_held && !q.rsp.bvalid) begin
      rd = reg_read(q, q.awaddr);
      wv = merge(rd[31:0], q.wdata, q.wstrb);
      n.aw_held = 1'b0;
      n.w_held = 1'b0;
      n.rsp.bvalid = 1'b1;
      n.rsp.bresp = rd[32] ? `DFM_RESP_OKAY : `DFM_RESP_SLVERR;
      if (rd[32]) begin
        for (int k = 0; k < `DFM_NUM_DI; k++) begin
          if (q.awaddr[7:0] == 8'(`DFM_OFS_DI_CFG0 + 4 * k)) begin
            n.di_cfg[k] = wv[8:0];
          end
        end
        for (int k = 0; k < `DFM_NUM_DO; k++) begin
          if (q.awaddr[7:0] == 8'(`DFM_OFS_DO_CFG0 + 4 * k)) begin
            n.do_cfg[k] = wv[8:0];
          end
        end
        case (q.awaddr[7:0])
          `DFM_OFS_FORCE_SEL: n.force_sel = wv[2:0];
          `DFM_OFS_FORCED_IN: n.forced_in = wv[`DFM_NUM_DI-1:0];
          `DFM_OFS_FORCED_OUT: n.forced_out = wv[`DFM_NUM_DO-1:0];
          `DFM_OFS_ROT_THRESH: n.thresh = wv[15:0];
          default: n.thresh = n.thresh;
        endcase
      end
    end
    if (q.rsp.bvalid && I_AXI_REQ.bready) begin
      n.rsp.bvalid = 1'b0;
      n.rsp.awready = 1'b1;
      n.rsp.wready = 1'b1;
    end

    // read answers one cycle after the address is taken
    if (q.rsp.arready && I_AXI_REQ.arvalid) begin
      rd = reg_read(q, I_AXI_REQ.araddr);
      n.rsp.rvalid = 1'b1;
      n.rsp.arready = 1'b0;
      n.rsp.rdata = rd[31:0];
      n.rsp.rresp = rd[32] ? `DFM_RESP_OKAY : `DFM_RESP_SLVERR;
    end
    if (q.rsp.rvalid && I_AXI_REQ.rready) begin
      n.rsp.rvalid = 1'b0;
      n.rsp.arready = 1'b1;
    end

    // three-stage synchroniser; a level is accepted once stages two and three agree
    n.sync1 = {I_SAFETY_INPUT_B, I_SAFETY_INPUT_A, I_DIN};
    n.sync2 = q.sync1;
    n.sync3 = q.sync2;
    n.pin_level = ((q.sync2 ~^ q.sync3) & q.sync3) | ((q.sync2 ^ q.sync3) & q.pin_level);
    n.din_level = force_in_mode ? q.forced_in : q.pin_level[`DFM_NUM_DI-1:0];

    // several terminals may share a code; their activity is ORed
    for (int k = 0; k < `DFM_NUM_DI; k++) begin
      active = q.din_level[k] ^ q.di_cfg[k].sense;
      code = q.di_cfg[k].code;
      case (code)
        `DFM_FI_MOTOR_EN: f.motor_enable = f.motor_enable | active;
        `DFM_FI_FAULT_CLR: f.fault_clear_in = f.fault_clear_in | active;
        `DFM_FI_FWD_LIMIT: f.forward_limit_in = f.forward_limit_in | active;
        `DFM_FI_REV_LIMIT: f.reverse_limit_in = f.reverse_limit_in | active;
        `DFM_FI_ORIGIN: f.origin_sensor_in = f.origin_sensor_in | active;
        `DFM_FI_HALT: f.emergency_halt_in = f.emergency_halt_in | active;
        `DFM_FI_LATCH_A: f.latch_trigger_a = f.latch_trigger_a | active;
        `DFM_FI_LATCH_B: f.latch_trigger_b = f.latch_trigger_b | active;
        default: f = f;
      endcase
    end
    // enable and fault clear only count in local control; levels, never edges
    f.motor_enable = f.motor_enable & ~I_DRIVE.bus_control;
    f.fault_clear_in = f.fault_clear_in & ~I_DRIVE.bus_control;
    n.in_func = f;

    for (int k = 0; k < `DFM_NUM_DO; k++) begin
      if (force_out_mode) begin
        active = q.forced_out[k];
      end else begin
        active = fn_out(q.do_cfg[k].code, I_DRIVE, q.thresh, q.pin_level[6:5]);
      end
      n.dout[k] = active ^ q.do_cfg[k].sense;
      // fieldbus override drives the raw level, bypassing the sense
      if (bus_out_mode && I_DRIVE.bus_do_enable[k]) begin
        n.dout[k] = I_DRIVE.bus_do_value[k];
      end
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      q <= '0;
      q.rsp.awready <= 1'b1;
      q.rsp.wready <= 1'b1;
      q.rsp.arready <= 1'b1;
      q.force_sel <= `DFM_FORCE_NONE;
      q.thresh <= `DFM_RST_THRESH;
    end else begin
      q <= n;
    end
  end

  assign O_AXI_RSP = q.rsp;
  assign O_DOUT = q.dout;
  assign O_IN_FUNC = q.in_func;

  default clocking dfm_cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_RESET);

  force_reset_a: assert property ($past(I_RESET) |-> q.force_sel == `DFM_FORCE_NONE)
    else $error("force select not cleared after reset");

  forced_in_a: assert property (force_in_mode |=> q.din_level == $past(q.forced_in))
    else $error("forced input value not applied");

  sequence din_quiet;
    (!force_in_mode && $stable(I_DIN))[*6];
  endsequence
  pin_filter_a: assert property (din_quiet |=> q.din_level == $past(I_DIN))
    else $error("steady pin level not passed to input level");

  motor_local_a: assert property (O_IN_FUNC.motor_enable |-> !$past(I_DRIVE.bus_control))
    else $error("motor enable active under bus control");

  fwd_limit_a: assert property ((q.di_cfg[0].code == `DFM_FI_FWD_LIMIT && !q.di_cfg[0].sense
                                 && q.din_level[0]) |=> O_IN_FUNC.forward_limit_in)
    else $error("forward limit not decoded");

  unassigned_in_a: assert property ((q.di_cfg[0].code != `DFM_FI_LATCH_A
      && q.di_cfg[1].code != `DFM_FI_LATCH_A && q.di_cfg[2].code != `DFM_FI_LATCH_A
      && q.di_cfg[3].code != `DFM_FI_LATCH_A && q.di_cfg[4].code != `DFM_FI_LATCH_A)
      |=> !O_IN_FUNC.latch_trigger_a)
    else $error("unassigned input function active");

  forced_out_a: assert property (force_out_mode |=> O_DOUT ==
      $past(q.forced_out ^ {q.do_cfg[2].sense, q.do_cfg[1].sense, q.do_cfg[0].sense}))
    else $error("forced output level wrong");

  unassigned_out_a: assert property ((!force_out_mode && !bus_out_mode
      && q.do_cfg[0].code == `DFM_CODE_NONE) |=> O_DOUT[0] == $past(q.do_cfg[0].sense))
    else $error("unassigned output not at inactive level");

  safe_torque_a: assert property ((!force_out_mode && !bus_out_mode
      && q.do_cfg[0].code == `DFM_FO_SAFE_TORQUE && !q.do_cfg[0].sense)
      |=> O_DOUT[0] == $past(q.pin_level[6:5] == 2'h0))
    else $error("safe torque status wrong");

  rotating_a: assert property ((!force_out_mode && !bus_out_mode
      && q.do_cfg[1].code == `DFM_FO_ROTATING && !q.do_cfg[1].sense)
      |=> O_DOUT[1] == $past(abs16(I_DRIVE.filt_speed) >= q.thresh))
    else $error("rotation output disagrees with threshold");

  // raw bus level wins over function and sense on an enabled terminal
  bus_override_a: assert property ((bus_out_mode && I_DRIVE.bus_do_enable[2])
      |=> O_DOUT[2] == $past(I_DRIVE.bus_do_value[2]))
    else $error("fieldbus output override not applied");

  sequence rd_taken;
    I_AXI_REQ.arvalid && O_AXI_RSP.arready;
  endsequence
  read_answer_a: assert property (rd_taken |=> O_AXI_RSP.rvalid && !O_AXI_RSP.arready)
    else $error("read not answered in one cycle");

  sequence wr_both_held;
    q.aw_held && q.w_held && !O_AXI_RSP.bvalid;
  endsequence
  write_answer_a: assert property (wr_both_held |=> O_AXI_RSP.bvalid)
    else $error("write response missing");
endmodule

// file: sim/dfm_host_wiring.sv
// host controller wiring model: drives input terminals and safety pins, watches outputs
`timescale 1ns/100ps
`include "dfm_consts.svh"
module dfm_host_wiring (
  input wire logic i_core_clk,
  input wire logic [`DFM_NUM_DI-1:0] i_set_din,
  input wire logic [1:0] i_set_safety,
  input wire logic [`DFM_NUM_DO-1:0] i_dout,
  output logic [`DFM_NUM_DI-1:0] o_din,
  output logic o_safety_a,
  output logic o_safety_b,
  output logic [`DFM_NUM_DO-1:0] o_seen_dout
);
  // wiring is always driven, so pins idle at the level last set
  initial begin
    o_din = '0;
    {o_safety_b, o_safety_a} = 2'h3;
    o_seen_dout = '0;
  end
  always @(posedge i_core_clk) begin
    o_din <= i_set_din;
    {o_safety_b, o_safety_a} <= i_set_safety;
    o_seen_dout <= i_dout;
  end
endmodule

// file: sim/dio_function_mapper_test.sv
// self-checking testbench for the digital I/O function mapper
`timescale 1ns/100ps
`include "dfm_consts.svh"
module dio_function_mapper_test;
  import dfm_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  dfm_axi_req_t req = '0;
  dfm_axi_rsp_t rsp;
  dfm_drive_t drv = '0;
  logic [4:0] set_din = 5'h00;
  logic [1:0] set_safety = 2'h3;
  logic [4:0] din;
  logic sa;
  logic sb;
  logic [2:0] dout;
  logic [2:0] seen;
  dfm_in_func_t in_func;
  int fail_count = 0;
  int total_checks = 0;
  logic [31:0] rd;
  logic [1:0] resp;
  // position in the array is the bit position in the function vector
  logic [7:0] in_codes [8] = '{`DFM_FI_LATCH_B, `DFM_FI_LATCH_A, `DFM_FI_HALT, `DFM_FI_ORIGIN,
    `DFM_FI_REV_LIMIT, `DFM_FI_FWD_LIMIT, `DFM_FI_FAULT_CLR, `DFM_FI_MOTOR_EN};
  logic [7:0] out_codes [7] = '{`DFM_FO_READY, `DFM_FO_ROTATING, `DFM_FO_BRAKE,
    `DFM_FO_WARNING, `DFM_FO_FAULT, `DFM_FO_POS_CMP, `DFM_FO_SAFE_TORQUE};
  logic [7:0] force_in_exp [6] = '{8'h20, 8'h30, 8'h20, 8'h30, 8'h20, 8'h20};
  logic [2:0] force_out_exp [6] = '{3'h0, 3'h0, 3'h3, 3'h3, 3'h4, 3'h0};

  initial begin
    forever #10 core_clk = ~core_clk;
  end

  dfm_mapper uut (.I_CORE_CLK(core_clk), .I_RESET(reset), .I_AXI_REQ(req), .O_AXI_RSP(rsp),
    .I_DIN(din), .I_SAFETY_INPUT_A(sa), .I_SAFETY_INPUT_B(sb), .I_DRIVE(drv),
    .O_DOUT(dout), .O_IN_FUNC(in_func));

  dfm_host_wiring host (.i_core_clk(core_clk), .i_set_din(set_din), .i_set_safety(set_safety),
    .i_dout(dout), .o_din(din), .o_safety_a(sa), .o_safety_b(sb), .o_seen_dout(seen));

  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task check(input logic [31:0] act, input logic [31:0] exp);
    total_checks++;
    if (act !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, act, exp);
    end
  endtask

  // pins pass a synchroniser plus the host's own sampling flop
  task settle;
    repeat (10) @(posedge core_clk);
  endtask

  task axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge core_clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid === 1'b1) break;
    end
    if (n == 50) begin
      fail_count++;
      stop_test;
    end
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  task axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge core_clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid === 1'b1) break;
    end
    if (n == 50) begin
      fail_count++;
      stop_test;
    end
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  task set_cause(input int i, input logic on);
    case (i)
      0: drv.drive_ready <= on;
      1: drv.filt_speed <= on ? -16'sd200 : -16'sd199;
      2: drv.brake_active <= on;
      3: drv.warning <= on;
      4: drv.fault <= on;
      5: drv.pos_passed <= on;
      default: set_safety <= on ? 2'b00 : 2'b10;
    endcase
  endtask

  task test_regs;
    axi_rd(`DFM_OFS_FORCE_SEL, rd, resp);
    check(rd, 32'h0);
    axi_rd(`DFM_OFS_ROT_THRESH, rd, resp);
    check(rd, 32'h0000_00C8);
    axi_rd(32'h0000_0040, rd, resp);
    check(rd, 32'h0);
    check(32'(resp), 32'(`DFM_RESP_SLVERR));
    axi_wr(32'h0000_0040, 32'hFFFF_FFFF, resp);
    check(32'(resp), 32'(`DFM_RESP_SLVERR));
    axi_wr(`DFM_OFS_DI_CFG0 + 32'h4, 32'h0000_010E, resp);
    axi_rd(`DFM_OFS_DI_CFG0 + 32'h4, rd, resp);
    check(rd, 32'h0000_010E);
    axi_wr(`DFM_OFS_STATUS, 32'hFFFF_FFFF, resp);
    check(32'(resp), 32'(`DFM_RESP_OKAY));
    settle;
    axi_rd(`DFM_OFS_STATUS, rd, resp);
    check(rd, 32'h0020_3000);
    axi_wr(`DFM_OFS_DI_CFG0 + 32'h4, 32'h0, resp);
  endtask

  task test_inputs;
    logic [31:0] a;
    logic [7:0] e;
    for (int i = 0; i < 8; i++) begin
      a = 32'(4 * (i % 5));
      e = 8'h01 << i;
      set_din <= 5'h1F;
      axi_wr(a, {23'h0, 1'b0, in_codes[i]}, resp);
      settle;
      check(32'(in_func), 32'(e));
      axi_wr(a, {23'h0, 1'b1, in_codes[i]}, resp);
      settle;
      check(32'(in_func), 32'h0);
      set_din <= 5'h00;
      settle;
      check(32'(in_func), 32'(e));
      drv.bus_control <= 1'b1;
      settle;
      check(32'(in_func), i > 5 ? 32'h0 : 32'(e));
      drv.bus_control <= 1'b0;
      axi_wr(a, 32'h0, resp);
    end
  endtask

  task test_outputs;
    logic [31:0] a;
    logic [2:0] e;
    for (int i = 0; i < 7; i++) begin
      a = `DFM_OFS_DO_CFG0 + 32'(4 * (i % 3));
      e = 3'b001 << (i % 3);
      axi_wr(a, {23'h0, 1'b0, out_codes[i]}, resp);
      set_cause(i, 1'b1);
      settle;
      check(32'(seen), 32'(e));
      axi_wr(a, {23'h0, 1'b1, out_codes[i]}, resp);
      settle;
      check(32'(seen), 32'h0);
      set_cause(i, 1'b0);
      settle;
      check(32'(seen), 32'(e));
      axi_wr(a, 32'h0, resp);
      settle;
      check(32'(seen), 32'h0);
    end
    set_safety <= 2'h3;
  endtask

  // modes 0 to 4 and one out-of-range value against one fixed setup
  task test_force;
    axi_wr(`DFM_OFS_DI_CFG0, {23'h0, 1'b1, `DFM_FI_FWD_LIMIT}, resp);
    axi_wr(`DFM_OFS_DI_CFG0 + 32'h4, {23'h0, 1'b0, `DFM_FI_REV_LIMIT}, resp);
    axi_wr(`DFM_OFS_DO_CFG0, {23'h0, 1'b1, `DFM_FO_READY}, resp);
    axi_wr(`DFM_OFS_DO_CFG0 + 32'h4, {23'h0, 1'b0, `DFM_FO_BRAKE}, resp);
    axi_wr(`DFM_OFS_FORCED_IN, 32'h1E, resp);
    axi_wr(`DFM_OFS_FORCED_OUT, 32'h2, resp);
    drv.drive_ready <= 1'b1;
    drv.bus_do_enable <= 3'b100;
    drv.bus_do_value <= 3'b100;
    for (int m = 0; m < 6; m++) begin
      axi_wr(`DFM_OFS_FORCE_SEL, 32'(m), resp);
      settle;
      check(32'(in_func), 32'(force_in_exp[m]));
      check(32'(seen), 32'(force_out_exp[m]));
    end
  endtask

  task test_restart;
    axi_wr(`DFM_OFS_FORCE_SEL, 32'(`DFM_FORCE_BOTH), resp);
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    axi_rd(`DFM_OFS_FORCE_SEL, rd, resp);
    check(rd, 32'h0);
    settle;
    check(32'(seen), 32'h0);
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    test_regs;
    test_inputs;
    test_outputs;
    test_force;
    test_restart;
    stop_test;
  end
endmodule
